// ---- rpm_cfg.svh ----
`ifndef RPM_CFG_SVH
`define RPM_CFG_SVH
// ----------------------------------------------------------------
// device register map (offsets on the sideband register port)
// ----------------------------------------------------------------
`define RPM_OFS_MODE      8'h09
`define RPM_OFS_SWEM      8'h0c
`define RPM_OFS_RATIO     8'h20
`define RPM_OFS_LANE      8'h30
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RPM_BIT_ALT       5
`define RPM_BIT_PD        3
`define RPM_BIT_HPDIGN    2
`define RPM_BIT_RATIO     1
`define RPM_BIT_TERM      0
// ----------------------------------------------------------------
// reset values and alternate-mode defaults
// ----------------------------------------------------------------
`define RPM_RST_MODE      8'h00
`define RPM_RST_SWEM      8'h00
`define RPM_RST_RATIO     8'h00
`define RPM_RST_LANE      8'h00
`define RPM_ALT_SWEM      8'h40
`define RPM_ALT_LANE      8'hfc
`define RPM_RATE_STRAP    2'b00
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RPM_CLK_HZ        20000000
`define RPM_HPD_LOW_US    2000
`define RPM_INVEST_NS     3000
`define RPM_HPD_LOW_CYC   ((`RPM_HPD_LOW_US * (`RPM_CLK_HZ / 1000) + 999) / 1000)
`define RPM_INVEST_CYC    ((`RPM_INVEST_NS * (`RPM_CLK_HZ / 1000000) + 999) / 1000)
// ----------------------------------------------------------------
// host command registers (avalon byte addresses)
// ----------------------------------------------------------------
`define RPM_AV_CTRL       5'h00
`define RPM_AV_ADDR       5'h04
`define RPM_AV_WDATA      5'h08
`define RPM_AV_RDATA      5'h0c
`define RPM_AV_STATUS     5'h10
`define RPM_AV_OE         5'h14
`endif

// ---- rpm_pkg.sv ----
package rpm_pkg;
  typedef logic [7:0] rpm_byte_t;
  // gray path: power down -> standby 1 -> standby 2 -> normal
  typedef enum logic [1:0] {
    RPM_PDOWN  = 2'b00,
    RPM_STBY1  = 2'b01,
    RPM_STBY2  = 2'b11,
    RPM_NORMAL = 2'b10
  } rpm_state_e;
endpackage

// ---- rpm_link_if.sv ----
`timescale 1ns/1ps
interface rpm_link_if (
  input wire logic clk_sys
);
  import rpm_pkg::*;
  logic      reg_req;
  logic      reg_we;
  rpm_byte_t reg_addr;
  rpm_byte_t reg_wdata;
  rpm_byte_t reg_rdata;
  logic      reg_ack;
  logic      out_en_pin;
  logic      hot_plug_source_out;
  logic      dev_power_down;
  modport dev  (input reg_req, reg_we, reg_addr, reg_wdata, out_en_pin,
                output reg_rdata, reg_ack, hot_plug_source_out, dev_power_down);
  modport host (output reg_req, reg_we, reg_addr, reg_wdata, out_en_pin,
                input reg_rdata, reg_ack, hot_plug_source_out, dev_power_down);
endinterface // rpm_link_if

// ---- rpm_device.sv ----
// Notes on behaviour
// RULE1 - mode bit 5 at 0x09 selects alternate mode
// RULE2 - alternate entry loads defaults, straps ignored
// RULE3 - alternate defaults: four lanes, top rate
// RULE4 - host programs link setup, no training
// RULE5 - alternate swing from 0x0c bits 7:5
// RULE6 - alternate emphasis from 0x0c bits 1:0
// RULE7 - alternate lane enables, rate from 0x30[7:2]
// RULE8 - enable low forces lowest power state
// RULE9 - enable rising resets; host reprograms registers
// RULE10 - writing 0x09 bit 3 powers down
// RULE11 - hot-plug low beyond 2 ms powers down
// RULE12 - standby while hot-plug high, no clock
// RULE13 - outputs enabled only on valid clock
// RULE14 - source hot-plug follows sink hot-plug
// RULE15 - power-down entry clears all registers
// RULE16 - host rewrites clock ratio flag afterwards
// RULE17 - investigate clock line for 3 us
// RULE18 - clock found: go to normal
// RULE19 - no clock: back to standby stage 1
// RULE20 - sideband bypassed: termination from strap/registers
// RULE21 - 0x09 bit 2 ignores sink hot-plug
// RULE22 - standby: data receivers off, outputs high-z
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/1ps
`include "rpm_cfg.svh"
module rpm_device #(
  parameter int HPD_LOW_CYC = `RPM_HPD_LOW_CYC
) (
  input  wire logic     clk_sys,
  input  wire logic     rst_n,
  input  wire logic     ce,
  rpm_link_if.dev       link,
  input  wire logic     hot_plug_sink_in,
  input  wire logic     clk_lane_activity,
  input  wire logic     clk_lane_valid,
  input  wire logic     sideband_bypassed,
  input  wire logic     snoop_term_en,
  input  wire logic [2:0] strap_swing,
  input  wire logic [1:0] strap_emph,
  input  wire logic     strap_term,
  output logic          rx_data_en,
  output logic          rx_clk_en,
  output logic          tx_out_en,
  output logic [3:0]    lane_en,
  output logic [2:0]    swing_sel,
  output logic [1:0]    emph_sel,
  output logic [1:0]    rate_sel,
  output logic          term_en,
  output logic          clock_ratio_flag
);
  import rpm_pkg::*;

  localparam logic [6:0] INVEST_LAST = 7'(`RPM_INVEST_CYC - 1);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pin_raw;
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] sync3_reg;
  logic [3:0] pin_reg;
  logic       oe_f;
  logic       hpd_f;
  logic       act_f;
  logic       valid_f;

  assign pin_raw = {clk_lane_valid, clk_lane_activity, hot_plug_sink_in, link.out_en_pin};

  // three stages; a level is taken only when stages two and three agree
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      sync3_reg <= 4'h0;
      pin_reg   <= 4'h0;
    end else if (ce) begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      pin_reg   <= (~(sync2_reg ^ sync3_reg) & sync3_reg) | ((sync2_reg ^ sync3_reg) & pin_reg);
    end
  end

  assign {valid_f, act_f, hpd_f, oe_f} = pin_reg;

  // ----------------------------------------------------------------
  // control state
  // ----------------------------------------------------------------
  rpm_state_e state_reg;
  rpm_state_e state_next;
  rpm_byte_t  mode_reg;
  rpm_byte_t  swem_reg;
  rpm_byte_t  ratio_reg;
  rpm_byte_t  lane_reg;
  logic       oe_prev_reg;
  logic       pd_latch_reg;
  logic [15:0] hpd_cnt_reg;
  logic [6:0] inv_cnt_reg;
  logic       ack_reg;
  rpm_byte_t  rdata_reg;
  logic       oe_rise;
  logic       hpd_expired;
  logic       hpd_ok;
  logic       pd_cond;
  logic       pd_enter;
  logic       wr_take;
  logic       wr_mode;
  logic       alt_on;

  assign oe_rise     = oe_f & ~oe_prev_reg;
  assign hpd_expired = hpd_cnt_reg == 16'(HPD_LOW_CYC);
  assign hpd_ok      = hpd_f | mode_reg[`RPM_BIT_HPDIGN];                        // [RULE21]
  // any of the three causes holds the block in power down
  assign pd_cond     = ~oe_f | pd_latch_reg | hpd_expired;             // [RULE8] [RULE10] [RULE11]
  assign pd_enter    = (state_reg != RPM_PDOWN) & pd_cond;
  assign wr_take     = link.reg_req & link.reg_we & ~ack_reg;
  assign wr_mode     = wr_take & (link.reg_addr == `RPM_OFS_MODE);
  assign alt_on      = mode_reg[`RPM_BIT_ALT];

  // enable edge detect and hot-plug low timer
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      oe_prev_reg <= 1'b0;
      hpd_cnt_reg <= 16'h0000;
    end else if (ce) begin
      oe_prev_reg <= oe_f;
      if (!oe_f || hpd_f) begin
        hpd_cnt_reg <= 16'h0000;
      end else if (!hpd_expired) begin
        hpd_cnt_reg <= hpd_cnt_reg + 16'h0001;                                   // [RULE11]
      end
    end
  end

  // register power-down request is held until released by a mode write
  // or by an enable rising; the clear on entry would otherwise drop it
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pd_latch_reg <= 1'b0;
    end else if (ce) begin
      if (oe_rise) begin
        pd_latch_reg <= 1'b0;
      end else if (wr_mode) begin
        pd_latch_reg <= link.reg_wdata[`RPM_BIT_PD];                             // [RULE10]
      end
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mode_reg  <= `RPM_RST_MODE;
      swem_reg  <= `RPM_RST_SWEM;
      ratio_reg <= `RPM_RST_RATIO;
      lane_reg  <= `RPM_RST_LANE;
    end else if (ce) begin
      if (pd_enter || oe_rise) begin
        // a power-down or re-enable wipes all settings
        mode_reg  <= `RPM_RST_MODE;                                      // [RULE9] [RULE15]
        swem_reg  <= `RPM_RST_SWEM;
        ratio_reg <= `RPM_RST_RATIO;
        lane_reg  <= `RPM_RST_LANE;
      end else if (wr_mode) begin
        mode_reg <= link.reg_wdata;                                                // [RULE1]
        if (link.reg_wdata[`RPM_BIT_ALT] && !alt_on) begin
          swem_reg <= `RPM_ALT_SWEM;                                               // [RULE2]
          lane_reg <= `RPM_ALT_LANE;                                               // [RULE3]
        end
      end else if (wr_take) begin
        case (link.reg_addr)
          `RPM_OFS_SWEM:  swem_reg  <= link.reg_wdata;
          `RPM_OFS_RATIO: ratio_reg <= link.reg_wdata;
          `RPM_OFS_LANE:  lane_reg  <= link.reg_wdata;
          default:        ;
        endcase
      end
    end
  end

  // one ack per held request; read data captured at the same edge
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 8'h00;
    end else if (ce) begin
      ack_reg <= link.reg_req & ~ack_reg;
      if (link.reg_req && !ack_reg) begin
        case (link.reg_addr)
          `RPM_OFS_MODE:  rdata_reg <= mode_reg;
          `RPM_OFS_SWEM:  rdata_reg <= swem_reg;
          `RPM_OFS_RATIO: rdata_reg <= ratio_reg;
          `RPM_OFS_LANE:  rdata_reg <= lane_reg;
          default:        rdata_reg <= 8'h00;
        endcase
      end
    end
  end

  assign link.reg_ack   = ack_reg;
  assign link.reg_rdata = rdata_reg;

  // ----------------------------------------------------------------
  // power state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      RPM_PDOWN: begin
        state_next = RPM_STBY1;
      end
      RPM_STBY1: begin
        if (hpd_ok && act_f) begin
          state_next = RPM_STBY2;                                                 // [RULE12]
        end
      end
      RPM_STBY2: begin
        if (!hpd_ok) begin
          state_next = RPM_STBY1;
        end else if (inv_cnt_reg == INVEST_LAST) begin
          state_next = valid_f ? RPM_NORMAL : RPM_STBY1;                 // [RULE18] [RULE19]
        end
      end
      RPM_NORMAL: begin
        if (!hpd_ok || !valid_f) begin
          state_next = RPM_STBY1;                                                 // [RULE13]
        end
      end
      default: begin
        state_next = RPM_PDOWN;
      end
    endcase
    if (pd_cond) begin
      state_next = RPM_PDOWN;                                                     // [RULE8]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= RPM_PDOWN;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  // investigation window counter, restarts on every entry to stage two
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      inv_cnt_reg <= 7'h00;
    end else if (ce) begin
      if (state_reg != RPM_STBY2) begin
        inv_cnt_reg <= 7'h00;
      end else if (inv_cnt_reg != INVEST_LAST) begin
        inv_cnt_reg <= inv_cnt_reg + 7'h01;                                       // [RULE17]
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs, all registered; enables and power-down from the next state
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rx_data_en       <= 1'b0;
      rx_clk_en        <= 1'b0;
      tx_out_en        <= 1'b0;
      lane_en          <= 4'h0;
      swing_sel        <= 3'h0;
      emph_sel         <= 2'h0;
      rate_sel         <= 2'h0;
      term_en          <= 1'b0;
      clock_ratio_flag <= 1'b0;
      link.hot_plug_source_out <= 1'b0;
      link.dev_power_down      <= 1'b1;
    end else if (ce) begin
      rx_data_en <= state_next == RPM_NORMAL;                                     // [RULE22]
      rx_clk_en  <= state_next != RPM_PDOWN;
      tx_out_en  <= state_next == RPM_NORMAL;                                     // [RULE13]
      if (state_next != RPM_NORMAL) begin
        lane_en <= 4'h0;
      end else begin
        lane_en <= alt_on ? lane_reg[7:4] : 4'hf;                                 // [RULE7]
      end
      // in alternate mode straps no longer steer anything
      swing_sel <= alt_on ? swem_reg[7:5] : strap_swing;                 // [RULE2] [RULE5]
      emph_sel  <= alt_on ? swem_reg[1:0] : strap_emph;                           // [RULE6]
      rate_sel  <= alt_on ? lane_reg[3:2] : `RPM_RATE_STRAP;                      // [RULE7]
      if (sideband_bypassed) begin
        term_en <= alt_on ? ratio_reg[`RPM_BIT_TERM] : strap_term;                // [RULE20]
      end else begin
        term_en <= snoop_term_en;
      end
      clock_ratio_flag         <= ratio_reg[`RPM_BIT_RATIO];
      link.hot_plug_source_out <= hpd_f;                                          // [RULE14]
      link.dev_power_down      <= state_next == RPM_PDOWN;
    end
  end
endmodule // rpm_device

// ---- rpm_host.sv ----
`timescale 1ns/1ps
`include "rpm_cfg.svh"
module rpm_host (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        ce,
  rpm_link_if.host         link,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);
  import rpm_pkg::*;

  // ----------------------------------------------------------------
  // command registers
  // ----------------------------------------------------------------
  logic      busy_reg;
  logic      we_reg;
  rpm_byte_t addr_reg;
  rpm_byte_t wdata_reg;
  rpm_byte_t rdata_reg;
  logic      oe_reg;
  logic      lost_reg;
  logic      pd_prev_reg;
  logic      oe_prev_reg;
  logic      rd_ok_reg;
  logic      ctrl_stall;
  logic      wr_ok;
  logic [31:0] rd_mux;

  // a new command waits while the last one is still on the link
  assign ctrl_stall      = avs_write & (avs_address == `RPM_AV_CTRL) & busy_reg;
  assign avs_waitrequest = ctrl_stall | (avs_read & ~rd_ok_reg);
  assign wr_ok           = avs_write & ~ctrl_stall;

  // start bit launches one register access toward the device
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      busy_reg  <= 1'b0;
      we_reg    <= 1'b0;
      addr_reg  <= 8'h00;
      wdata_reg <= 8'h00;
      rdata_reg <= 8'h00;
    end else if (ce) begin
      if (busy_reg && link.reg_ack) begin
        busy_reg <= 1'b0;
        if (!we_reg) begin
          rdata_reg <= link.reg_rdata;
        end
      end
      if (wr_ok) begin
        case (avs_address)
          `RPM_AV_CTRL: begin
            if (avs_writedata[0]) begin
              busy_reg <= 1'b1;                                          // [RULE1] [RULE4]
              we_reg   <= avs_writedata[1];
            end
          end
          `RPM_AV_ADDR:  addr_reg  <= avs_writedata[7:0];
          `RPM_AV_WDATA: wdata_reg <= avs_writedata[7:0];
          default:       ;
        endcase
      end
    end
  end

  // enable pin and the lost-settings flag; a new loss beats a clear
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      oe_reg      <= 1'b0;
      oe_prev_reg <= 1'b0;
      pd_prev_reg <= 1'b1;                  // power-down is the reset level
      lost_reg    <= 1'b0;
    end else if (ce) begin
      oe_prev_reg <= oe_reg;
      pd_prev_reg <= link.dev_power_down;
      if (wr_ok && avs_address == `RPM_AV_OE) begin
        oe_reg <= avs_writedata[0];
      end
      if ((oe_reg && !oe_prev_reg) || (link.dev_power_down && !pd_prev_reg)) begin
        lost_reg <= 1'b1;                                                 // [RULE9] [RULE16]
      end else if (wr_ok && avs_address == `RPM_AV_STATUS && avs_writedata[3]) begin
        lost_reg <= 1'b0;
      end
    end
  end

  assign link.reg_req    = busy_reg;
  assign link.reg_we     = we_reg;
  assign link.reg_addr   = addr_reg;
  assign link.reg_wdata  = wdata_reg;
  assign link.out_en_pin = oe_reg;

  // ----------------------------------------------------------------
  // avalon read path, one wait cycle
  // ----------------------------------------------------------------
  always_comb begin
    case (avs_address)
      `RPM_AV_CTRL:   rd_mux = {30'h0, we_reg, busy_reg};
      `RPM_AV_ADDR:   rd_mux = {24'h0, addr_reg};
      `RPM_AV_WDATA:  rd_mux = {24'h0, wdata_reg};
      `RPM_AV_RDATA:  rd_mux = {24'h0, rdata_reg};
      `RPM_AV_STATUS: rd_mux = {28'h0, lost_reg, link.dev_power_down,
                                link.hot_plug_source_out, busy_reg};
      `RPM_AV_OE:     rd_mux = {31'h0, oe_reg};
      default:        rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rd_ok_reg    <= 1'b0;
      avs_readdata <= 32'h0;
    end else if (ce) begin
      rd_ok_reg <= avs_read & ~rd_ok_reg;
      if (avs_read && !rd_ok_reg) begin
        avs_readdata <= rd_mux;
      end
    end
  end
endmodule // rpm_host

// ---- rpm_link_asserts.sv ----
`timescale 1ns/1ps
`include "rpm_cfg.svh"
module rpm_link_asserts #(
  parameter int HPD_LOW_CYC = 20
) (
  input wire logic             clk_sys,
  input wire logic             rst_n,
  input wire logic             reg_req,
  input wire logic             reg_we,
  input wire rpm_pkg::rpm_byte_t reg_addr,
  input wire rpm_pkg::rpm_byte_t reg_wdata,
  input wire rpm_pkg::rpm_byte_t reg_rdata,
  input wire logic             reg_ack,
  input wire logic             out_en_pin,
  input wire logic             hot_plug_source_out,
  input wire logic             dev_power_down
);
  import rpm_pkg::*;
  // ----------------------------------------------------------------
  // helper: cycles of hot-plug low while enabled
  // ----------------------------------------------------------------
  // slack of five covers sync stages and the output register
  localparam int LO_LIM = HPD_LOW_CYC + 5;
  int lo_cnt_reg;
  // saturates just past the limit so the check fires once per episode
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !out_en_pin || hot_plug_source_out) lo_cnt_reg <= 0;
    else if (lo_cnt_reg <= LO_LIM) lo_cnt_reg <= lo_cnt_reg + 1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // link handshake and power-down causes
  // ----------------------------------------------------------------
  ack_one_shot_a: assert property (reg_ack |=> !reg_ack)
    else $error("link ack longer than one cycle");
  ack_follows_req_a: assert property ($rose(reg_req) |=> reg_ack)
    else $error("link ack not one cycle after request");
  ack_with_req_a: assert property (reg_ack |-> reg_req)
    else $error("link ack without request");
  req_steady_a: assert property (reg_req && !reg_ack |=>
      reg_req && $stable(reg_addr) && $stable(reg_we) && $stable(reg_wdata))
    else $error("link request changed before ack");
  oe_low_pd_a: assert property (!out_en_pin [*8] |-> dev_power_down)
    else $error("enable low but device not powered down");
  pd_exit_oe_a: assert property ($fell(dev_power_down) |-> $past(out_en_pin, 3))
    else $error("power down left without enable high");
  pd_write_a: assert property (reg_req && !reg_ack && reg_we
      && reg_addr == `RPM_OFS_MODE && reg_wdata[`RPM_BIT_PD] |-> ##[1:3] dev_power_down)
    else $error("power-down write did not power down");
  hpd_low_pd_a: assert property (lo_cnt_reg == LO_LIM |-> dev_power_down)
    else $error("long hot-plug low did not power down");
endmodule // rpm_link_asserts

// ---- redriver_power_mode_ctl_tb.sv ----
`timescale 1ns/1ps
`include "rpm_cfg.svh"
module redriver_power_mode_ctl_tb;
  import rpm_pkg::*;
  localparam int HPD_CYC = 20; // short hot-plug timeout keeps the run brief
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        ce = 1'b1;
  logic        hot_plug_sink_in = 1'b0;
  logic        clk_lane_activity = 1'b0;
  logic        clk_lane_valid = 1'b0;
  logic        sideband_bypassed = 1'b0;
  logic        snoop_term_en = 1'b0;
  logic [2:0]  strap_swing = 3'h5;
  logic [1:0]  strap_emph = 2'h1;
  logic        strap_term = 1'b0;
  logic        rx_data_en, rx_clk_en, tx_out_en, term_en, clock_ratio_flag;
  logic [3:0]  lane_en;
  logic [2:0]  swing_sel;
  logic [1:0]  emph_sel, rate_sel;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [31:0] seed = 32'h21;
  logic [63:0] exp_q[$];
  logic [63:0] note;
  int          err_count = 0;
  int          cmp_count = 0;
  always #25 clk_sys = ~clk_sys;
  // ----------------------------------------------------------------
  // design ends and checker
  // ----------------------------------------------------------------
  rpm_link_if link_bus (.clk_sys(clk_sys));
  rpm_device #(.HPD_LOW_CYC(HPD_CYC)) u_rpm_device (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
    .link(link_bus.dev), .hot_plug_sink_in(hot_plug_sink_in),
    .clk_lane_activity(clk_lane_activity), .clk_lane_valid(clk_lane_valid),
    .sideband_bypassed(sideband_bypassed), .snoop_term_en(snoop_term_en),
    .strap_swing(strap_swing), .strap_emph(strap_emph), .strap_term(strap_term),
    .rx_data_en(rx_data_en), .rx_clk_en(rx_clk_en), .tx_out_en(tx_out_en), .lane_en(lane_en),
    .swing_sel(swing_sel), .emph_sel(emph_sel), .rate_sel(rate_sel), .term_en(term_en),
    .clock_ratio_flag(clock_ratio_flag));
  rpm_host u_rpm_host (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .link(link_bus.host),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  rpm_link_asserts #(.HPD_LOW_CYC(HPD_CYC)) u_rpm_link_asserts (.clk_sys(clk_sys),
    .rst_n(rst_n), .reg_req(link_bus.reg_req), .reg_we(link_bus.reg_we),
    .reg_addr(link_bus.reg_addr), .reg_wdata(link_bus.reg_wdata),
    .reg_rdata(link_bus.reg_rdata), .reg_ack(link_bus.reg_ack),
    .out_en_pin(link_bus.out_en_pin), .hot_plug_source_out(link_bus.hot_plug_source_out),
    .dev_power_down(link_bus.dev_power_down));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // avalon master: request held until waitrequest is seen low at an edge
  task automatic av(input logic [4:0] a, input logic w, input logic [31:0] d,
                    input logic [31:0] m);
    int n;
    n = 0;
    if (!w) exp_q.push_back({m, d});
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= w ? d : 32'h0;
    // mid-cycle look equals what the next edge samples, free of races
    do begin
      @(negedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 200);
    if (n >= 200) err_count++;
    @(posedge clk_sys);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // a control write with start clear stalls until the link is idle
  task automatic dev_wr(input rpm_byte_t off, input rpm_byte_t dat);
    av(`RPM_AV_ADDR, 1'b1, {24'h0, off}, 32'h0);
    av(`RPM_AV_WDATA, 1'b1, {24'h0, dat}, 32'h0);
    av(`RPM_AV_CTRL, 1'b1, 32'h3, 32'h0);
    av(`RPM_AV_CTRL, 1'b1, 32'h0, 32'h0);
  endtask
  task automatic dev_rd(input rpm_byte_t off, input rpm_byte_t exp, input rpm_byte_t m);
    av(`RPM_AV_ADDR, 1'b1, {24'h0, off}, 32'h0);
    av(`RPM_AV_CTRL, 1'b1, 32'h1, 32'h0);
    av(`RPM_AV_CTRL, 1'b1, 32'h0, 32'h0);
    av(`RPM_AV_RDATA, 1'b0, {24'h0, exp}, {24'h0, m});
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic test_done;
    if (err_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // read monitor: oldest note against each accepted read
  always @(posedge clk_sys) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
      note = exp_q.pop_front();
      chk(avs_readdata & note[63:32], note[31:0] & note[63:32]);
    end
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    test_done;
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    step(4);
    chk({tx_out_en, rx_clk_en, rx_data_en}, 3'b000);
    av(`RPM_AV_STATUS, 1'b0, 32'h4, 32'h4);
    hot_plug_sink_in <= 1'b1;
    av(`RPM_AV_OE, 1'b1, 32'h1, 32'h0);
    step(10);
    chk({tx_out_en, rx_clk_en, rx_data_en}, 3'b010);
    av(`RPM_AV_STATUS, 1'b0, 32'h2, 32'h6);
    // clock investigation: noise only, then a real clock
    clk_lane_activity <= 1'b1;
    step(30);
    chk(tx_out_en, 1'b0);
    @(posedge clk_sys);
    clk_lane_activity <= 1'b0;
    step(60);
    chk({tx_out_en, rx_clk_en}, 2'b01);
    @(posedge clk_sys);
    clk_lane_activity <= 1'b1;
    clk_lane_valid <= 1'b1;
    step(50);
    chk(tx_out_en, 1'b0);
    step(25);
    chk({tx_out_en, rx_data_en}, 2'b11);
    // hot-plug ignore, then the long-low timeout
    dev_wr(`RPM_OFS_MODE, 8'h04);
    hot_plug_sink_in <= 1'b0;
    step(8);
    chk({tx_out_en, link_bus.hot_plug_source_out}, 2'b10);
    step(30);
    chk(tx_out_en, 1'b0);
    av(`RPM_AV_STATUS, 1'b0, 32'h4, 32'h6);
    hot_plug_sink_in <= 1'b1;
    step(10);
    dev_rd(`RPM_OFS_MODE, 8'h00, 8'hff);
    // register power-down, ratio flag clear, enable toggle
    dev_wr(`RPM_OFS_RATIO, 8'h02);
    step(3);
    chk(clock_ratio_flag, 1'b1);
    dev_wr(`RPM_OFS_MODE, 8'h08);
    step(4);
    chk({clock_ratio_flag, tx_out_en, rx_clk_en}, 3'b000);
    av(`RPM_AV_STATUS, 1'b0, 32'h4, 32'h4);
    av(`RPM_AV_OE, 1'b1, 32'h0, 32'h0);
    step(10);
    chk({tx_out_en, rx_clk_en, rx_data_en}, 3'b000);
    av(`RPM_AV_OE, 1'b1, 32'h1, 32'h0);
    step(70);
    av(`RPM_AV_STATUS, 1'b0, 32'ha, 32'he);
    av(`RPM_AV_STATUS, 1'b1, 32'h8, 32'h0);
    av(`RPM_AV_STATUS, 1'b0, 32'h0, 32'h8);
    dev_rd(`RPM_OFS_RATIO, 8'h00, 8'hff);
    // alternate mode defaults, then register-only control
    dev_wr(`RPM_OFS_MODE, 8'h20);
    step(3);
    chk({lane_en, rate_sel, swing_sel, emph_sel}, {4'hf, 2'h3, 3'h2, 2'h0});
    dev_rd(`RPM_OFS_SWEM, 8'h40, 8'hff);
    dev_rd(`RPM_OFS_LANE, 8'hfc, 8'hfc);
    strap_swing <= ~strap_swing;
    strap_emph <= ~strap_emph;
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      dev_wr(`RPM_OFS_SWEM, seed[7:0]);
      dev_wr(`RPM_OFS_LANE, seed[15:8]);
      step(3);
      chk({swing_sel, emph_sel}, {seed[7:5], seed[1:0]});
      chk({lane_en, rate_sel}, seed[15:10]);
      dev_rd(`RPM_OFS_LANE, seed[15:8], 8'hfc);
    end
    sideband_bypassed <= 1'b1;
    dev_wr(`RPM_OFS_RATIO, 8'h01);
    step(3);
    chk(term_en, 1'b1);
    // unmapped places read as zero
    dev_rd(8'h55, 8'h00, 8'hff);
    av(5'h1c, 1'b0, 32'h0, 32'hffffffff);
    // clock enable (ce) low must freeze the outputs
    ce <= 1'b0;
    sideband_bypassed <= 1'b0;
    step(3);
    chk(term_en, 1'b1);
    @(posedge clk_sys);
    ce <= 1'b1;
    step(2);
    chk(term_en, 1'b0);
    step(4);
    if (exp_q.size() != 0) err_count++;
    test_done;
  end
endmodule // redriver_power_mode_ctl_tb
